// [core/aisc_pkg.sv]
package aisc_pkg;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int aisc_ceil_div(input int num, input int den);
    return (num + den - 1) / den;
  endfunction : aisc_ceil_div

  // ----------------------------------------------------------------
  // timing, counted in conversion clock periods
  // ----------------------------------------------------------------
  localparam int CONV_PERIOD_US  = 1;
  localparam int START_PULSE_US  = 15;
  localparam int NOISE_PERIOD_US = 130;
  localparam int HOLD_US         = 18;
  localparam int LAUNCH_US       = 4;
  localparam logic [15:0] START_PULSE_TICKS =
    16'(aisc_ceil_div(START_PULSE_US, CONV_PERIOD_US));
  localparam logic [15:0] NOISE_TICKS =
    16'(NOISE_PERIOD_US / CONV_PERIOD_US);
  localparam logic [4:0]  HOLD_TICKS =
    5'(aisc_ceil_div(HOLD_US, CONV_PERIOD_US));
  localparam logic [4:0]  LAUNCH_TICKS =
    5'(aisc_ceil_div(LAUNCH_US, CONV_PERIOD_US));
  localparam logic [9:0]  BUCKETS    = 10'h258;
  localparam logic [3:0]  SAR_MSB    = 4'hb;
  localparam logic [11:0] SAR_FIRST  = 12'h800;
  localparam logic [15:0] NO_AUTO    = 16'hffff;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_BUCKET  = 8'h04;
  localparam logic [7:0]  ADDR_RETRACE = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
  localparam logic [7:0]  ADDR_RESULT  = 8'h10;
  localparam logic [15:0] BUCKET_RST   = 16'h029b;
  localparam logic [15:0] RETRACE_RST  = 16'h03e8;
  localparam int          CTRL_W       = 9;
  localparam int          STAT_BKT_LSB = 8;
  localparam int          RES_CNT_LSB  = 16;

  // ----------------------------------------------------------------
  // detector modes and multiplexer codes {line1, line15, line16}
  // ----------------------------------------------------------------
  localparam logic [1:0] DET_SAMPLE = 2'h0;
  localparam logic [1:0] DET_POS    = 2'h1;
  localparam logic [1:0] DET_NEG    = 2'h2;
  localparam logic [1:0] DET_NOISE  = 2'h3;

  localparam logic [2:0] MUX_VIDEO = 3'h5;
  localparam logic [2:0] MUX_POS   = 3'h4;
  localparam logic [2:0] MUX_NEG   = 3'h1;
  localparam logic [2:0] MUX_RAMP  = 3'h3;
  localparam logic [2:0] MUX_OSC   = 3'h0;
  localparam logic [2:0] MUX_FC    = 3'h2;
  localparam logic [2:0] MUX_CAL   = 3'h6;
  localparam logic [2:0] MUX_OFL   = 3'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       run;
    logic       realign;
    logic [1:0] diag_sel;
    logic       diag_en;
    logic       wide_sweep;
    logic       zero_span;
    logic [1:0] det;
  } aisc_ctrl_t;

  typedef struct packed {
    logic [2:0] mux;
    logic       start_a;
    logic       start_b;
  } aisc_sel_t;

endpackage : aisc_pkg

// [core/aisc_tick_timer.sv]
`timescale 1ns/1ns
module aisc_tick_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        enable,
  input  wire logic        restart,
  input  wire logic [15:0] period,
  input  wire logic [15:0] width,
  output logic             fire,
  output logic             level
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] wid;
    logic        level;
    logic        fire;
  } aisc_tmr_st_t;

  aisc_tmr_st_t s;
  aisc_tmr_st_t next_s;

  // ----------------------------------------------------------------
  // period and width counting
  // ----------------------------------------------------------------
  always_comb begin
    next_s      = s;
    next_s.fire = 1'b0;
    if (!enable) begin
      next_s = '0;
    end else if (restart || (tick && s.cnt >= period - 16'h0001)) begin
      next_s.cnt   = '0;
      next_s.wid   = width;
      next_s.level = 1'b1;
      next_s.fire  = 1'b1;
    end else if (tick) begin
      next_s.cnt = s.cnt + 16'h0001;
      if (s.wid <= 16'h0001) begin
        next_s.wid   = '0;
        next_s.level = 1'b0;
      end else begin
        next_s.wid = s.wid - 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fire  = s.fire;
  assign level = s.level;

endmodule : aisc_tick_timer

// [core/aisc_sar.sv]
`timescale 1ns/1ns
module aisc_sar (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        comparator_high,
  output logic [11:0]      dac_code,
  output logic [11:0]      result,
  output logic             busy,
  output logic             complete_n
);

  typedef struct packed {
    logic [11:0] code;
    logic [11:0] result;
    logic [3:0]  bitidx;
    logic        busy;
    logic        complete_n;
  } aisc_sar_st_t;

  aisc_sar_st_t s;
  aisc_sar_st_t next_s;

  // ----------------------------------------------------------------
  // one trial bit per conversion clock, msb first
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (start && !s.busy) begin
      next_s.code       = aisc_pkg::SAR_FIRST;                 // R18
      next_s.bitidx     = aisc_pkg::SAR_MSB;
      next_s.busy       = 1'b1;
      next_s.complete_n = 1'b1;
    end else if (s.busy && tick) begin
      // comparator high means the trial overshot: drop the bit
      if (comparator_high) begin
        next_s.code[s.bitidx] = 1'b0;                         // R5
      end
      if (s.bitidx == 4'h0) begin
        next_s.busy       = 1'b0;
        next_s.complete_n = 1'b0;                             // R18
        next_s.result     = next_s.code;
      end else begin
        next_s.bitidx               = s.bitidx - 4'h1;
        next_s.code[s.bitidx - 4'h1] = 1'b1;                  // R18
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{complete_n: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign dac_code   = s.code;
  assign result     = s.result;
  assign busy       = s.busy;
  assign complete_n = s.complete_n;

endmodule : aisc_sar

// [core/aisc_top.sv]
// Summary of operation
// R1 - select lines follow detector mode codes
// R2 - video, positive or negative peak routed
// R3 - wide sweeps select and follow ramp
// R4 - diagnostic inputs only in diag or retrace
// R5 - 12-bit trial code with result latch
// R6 - eight converter inputs selectable
// R7 - noise mode alternates positive and negative
// R8 - controller supplies continuous 1 MHz clock
// R9 - bucket pulse used only at zero span
// R10 - selected start line begins a conversion
// R11 - sample mode: line a high, b low
// R12 - noise mode: both start lines low
// R13 - realign: line a low, b high
// R14 - 15 us pulses per bucket, none in retrace
// R15 - noise mode adds 130 us start pulses
// R16 - sweep active high in sweep, low retrace
// R17 - hold strobe freezes video for conversion
// R18 - msb first, one bit per clock, complete low
// R19 - selects change only between conversions
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
module aisc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conversion_clock,
  input  wire logic        zero_span_bucket_pulse,
  input  wire logic        ramp_bucket_end,
  input  wire logic        noise_detected,
  input  wire logic        comparator_high,
  output logic [2:0]       mux_sel,
  output logic             start_sel_a,
  output logic             start_sel_b,
  output logic             start_source_pulse,
  output logic             bucket_start,
  output logic             sweep_active,
  output logic             track_hold_strobe,
  output logic [11:0]      dac_code,
  output logic             complete_n
);

  typedef struct packed {
    aisc_pkg::aisc_ctrl_t ctrl;
    logic [15:0]          bucket_us;
    logic [15:0]          retrace_us;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 cc_q;
    logic                 zb_q;
    logic                 rb_q;
    logic                 src_q;
    logic                 sweep_active;
    logic [9:0]           bucket_cnt;
    logic [15:0]          retrace_cnt;
    aisc_pkg::aisc_sel_t  sel;
    logic                 bucket_start;
    logic                 hold;
    logic                 pend;
    logic [4:0]           hold_cnt;
    logic                 launch;
    logic                 phase_neg;
    logic [15:0]          conv_cnt;
  } aisc_top_st_t;

  localparam aisc_top_st_t ST_RST = '{
    bucket_us:  aisc_pkg::BUCKET_RST,
    retrace_us: aisc_pkg::RETRACE_RST,
    default:    '0
  };

  aisc_top_st_t s;
  aisc_top_st_t next_s;

  logic        tick;
  logic        zb_edge;
  logic        rb_edge;
  logic        ext_timing;
  logic        ext_bucket;
  logic        bkt_fire;
  logic        bkt_level;
  logic        noise_level;
  logic        timers_on;
  logic [15:0] bkt_period;
  logic        src_now;
  logic        trig;
  logic        sar_busy;
  logic        sar_complete_n;
  logic [11:0] sar_result;
  logic [11:0] sar_code;
  logic        apb_setup;
  logic        apb_write;

  // ----------------------------------------------------------------
  // input selection and start line decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] aisc_pick_mux(
    input aisc_pkg::aisc_ctrl_t c,
    input logic                 active,
    input logic                 noisy,
    input logic                 neg_turn
  );
    logic [2:0] m;
    m = aisc_pkg::MUX_VIDEO;
    if (c.diag_en || (c.run && !active)) begin
      unique case (c.diag_sel)                                // R4
        2'h0: m = aisc_pkg::MUX_OSC;
        2'h1: m = aisc_pkg::MUX_FC;
        2'h2: m = aisc_pkg::MUX_CAL;
        2'h3: m = aisc_pkg::MUX_OFL;
      endcase
    end else if (c.wide_sweep) begin
      m = aisc_pkg::MUX_RAMP;                                 // R3
    end else begin
      unique case (c.det)                                     // R1 R2 R6
        aisc_pkg::DET_SAMPLE: m = aisc_pkg::MUX_VIDEO;
        aisc_pkg::DET_POS:    m = aisc_pkg::MUX_POS;
        aisc_pkg::DET_NEG:    m = aisc_pkg::MUX_NEG;
        aisc_pkg::DET_NOISE:
          m = (noisy && neg_turn) ? aisc_pkg::MUX_NEG
                                  : aisc_pkg::MUX_POS;        // R7
      endcase
    end
    return m;
  endfunction : aisc_pick_mux

  function automatic aisc_pkg::aisc_sel_t aisc_pick_sel(
    input aisc_pkg::aisc_ctrl_t c,
    input logic                 active,
    input logic                 noisy,
    input logic                 neg_turn
  );
    aisc_pkg::aisc_sel_t r;
    r.mux = aisc_pick_mux(c, active, noisy, neg_turn);
    if (c.realign) begin
      r.start_a = 1'b0;                                       // R13
      r.start_b = 1'b1;
    end else if (c.det == aisc_pkg::DET_NOISE) begin
      r.start_a = 1'b0;                                       // R12
      r.start_b = 1'b0;
    end else begin
      r.start_a = 1'b1;                                       // R11
      r.start_b = 1'b0;
    end
    return r;
  endfunction : aisc_pick_sel

  // ----------------------------------------------------------------
  // edge detection on the slow inputs
  // ----------------------------------------------------------------
  // inputs are synchronous to pclk, so one flop suffices per edge
  assign tick    = conversion_clock & ~s.cc_q;                // R8
  assign zb_edge = zero_span_bucket_pulse & ~s.zb_q;
  assign rb_edge = ramp_bucket_end & ~s.rb_q;

  // bucket pulse counts only at zero span, ramp compare on wide sweeps
  assign ext_timing = s.ctrl.zero_span | s.ctrl.wide_sweep;
  assign ext_bucket = s.ctrl.zero_span ? zb_edge              // R9
                                       : (s.ctrl.wide_sweep & rb_edge);
  assign bkt_period = ext_timing ? aisc_pkg::NO_AUTO : s.bucket_us;
  assign timers_on  = s.ctrl.run & s.sweep_active;            // R14

  // ----------------------------------------------------------------
  // start pulse generators
  // ----------------------------------------------------------------
  aisc_tick_timer u_bucket_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .enable  (timers_on),
    .restart (ext_bucket),
    .period  (bkt_period),
    .width   (aisc_pkg::START_PULSE_TICKS),
    .fire    (bkt_fire),
    .level   (bkt_level)
  );

  aisc_tick_timer u_noise_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .enable  (timers_on),
    .restart (1'b0),
    .period  (aisc_pkg::NOISE_TICKS),
    .width   (aisc_pkg::START_PULSE_TICKS),
    .fire    (),
    .level   (noise_level)
  );

  // ----------------------------------------------------------------
  // converter sequencer
  // ----------------------------------------------------------------
  aisc_sar u_sar (
    .pclk            (pclk),
    .presetn         (presetn),
    .tick            (tick),
    .start           (s.launch),
    .comparator_high (comparator_high),
    .dac_code        (sar_code),
    .result          (sar_result),
    .busy            (sar_busy),
    .complete_n      (sar_complete_n)
  );

  // the selected start line; a rising edge begins a conversion
  always_comb begin
    unique case ({s.sel.start_a, s.sel.start_b})              // R10
      2'b10:   src_now = bkt_level;
      2'b00:   src_now = s.bucket_start;
      2'b01:   src_now = s.ctrl.zero_span & zero_span_bucket_pulse;
      default: src_now = 1'b0;
    endcase
  end

  // edges during a conversion are dropped, not queued
  assign trig = src_now & ~s.src_q & ~s.pend & ~sar_busy;     // R10

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & s.pready & pwrite;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.cc_q   = conversion_clock;
    next_s.zb_q   = zero_span_bucket_pulse;
    next_s.rb_q   = ramp_bucket_end;
    next_s.src_q  = src_now;
    next_s.launch = 1'b0;

    // second start line: 130 us in noise mode, else per bucket
    next_s.bucket_start = (s.ctrl.det == aisc_pkg::DET_NOISE)
                          ? noise_level : bkt_level;          // R15 R14

    // sweep and retrace sequencing
    if (!s.ctrl.run) begin
      next_s.sweep_active = 1'b0;
      next_s.bucket_cnt   = '0;
      next_s.retrace_cnt  = '0;
    end else if (s.sweep_active) begin
      if (bkt_fire) begin
        if (s.bucket_cnt == aisc_pkg::BUCKETS - 10'h001) begin
          next_s.sweep_active = 1'b0;                         // R16
          next_s.bucket_cnt   = '0;
        end else begin
          next_s.bucket_cnt = s.bucket_cnt + 10'h001;
        end
      end
    end else if (tick) begin
      if (s.retrace_cnt >= s.retrace_us) begin
        next_s.sweep_active = 1'b1;                           // R16
        next_s.retrace_cnt  = '0;
      end else begin
        next_s.retrace_cnt = s.retrace_cnt + 16'h0001;
      end
    end

    // selects move only while nothing is in flight
    if (!s.pend && !sar_busy) begin
      next_s.sel = aisc_pick_sel(s.ctrl, s.sweep_active,
                                 noise_detected, s.phase_neg); // R19
    end

    // hold, then launch the trial sequence a few ticks later
    if (trig) begin
      next_s.hold     = 1'b1;                                 // R17
      next_s.pend     = 1'b1;
      next_s.hold_cnt = '0;
      next_s.conv_cnt = s.conv_cnt + 16'h0001;
      if (s.ctrl.det == aisc_pkg::DET_NOISE && noise_detected) begin
        next_s.phase_neg = ~s.phase_neg;                      // R7
      end
    end else if (s.pend && tick) begin
      next_s.hold_cnt = s.hold_cnt + 5'h01;
      if (s.hold_cnt == aisc_pkg::LAUNCH_TICKS - 5'h01) begin
        next_s.launch = 1'b1;
      end
      if (s.hold_cnt == aisc_pkg::HOLD_TICKS - 5'h01) begin
        next_s.hold = 1'b0;                                   // R17
        next_s.pend = 1'b0;
      end
    end

    // apb: one wait-free access phase, answer prepared in setup
    next_s.pready = apb_setup;
    if (apb_setup) begin
      next_s.pslverr = 1'b0;
      next_s.prdata  = '0;
      unique case (paddr)
        aisc_pkg::ADDR_CTRL:
          next_s.prdata[aisc_pkg::CTRL_W-1:0] = s.ctrl;
        aisc_pkg::ADDR_BUCKET:  next_s.prdata[15:0] = s.bucket_us;
        aisc_pkg::ADDR_RETRACE: next_s.prdata[15:0] = s.retrace_us;
        aisc_pkg::ADDR_STATUS: begin
          next_s.prdata[0]   = s.pend | sar_busy;
          next_s.prdata[1]   = sar_complete_n;
          next_s.prdata[2]   = s.sweep_active;
          next_s.prdata[7:3] = s.sel;
          next_s.prdata[aisc_pkg::STAT_BKT_LSB +: 10] = s.bucket_cnt;
        end
        aisc_pkg::ADDR_RESULT: begin
          next_s.prdata[11:0] = sar_result;
          next_s.prdata[aisc_pkg::RES_CNT_LSB +: 16] = s.conv_cnt;
        end
        default: next_s.pslverr = 1'b1;
      endcase
      // status and result are read-only
      if (pwrite && (paddr == aisc_pkg::ADDR_STATUS ||
                     paddr == aisc_pkg::ADDR_RESULT)) begin
        next_s.pslverr = 1'b1;
      end
    end else if (!psel || penable) begin
      if (!psel) begin
        next_s.pslverr = 1'b0;
      end
    end

    if (apb_write) begin
      unique case (paddr)
        aisc_pkg::ADDR_CTRL:
          next_s.ctrl = aisc_pkg::aisc_ctrl_t'(
                          pwdata[aisc_pkg::CTRL_W-1:0]);
        aisc_pkg::ADDR_BUCKET:  next_s.bucket_us  = pwdata[15:0];
        aisc_pkg::ADDR_RETRACE: next_s.retrace_us = pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata             = s.prdata;
  assign pready             = s.pready;
  assign pslverr            = s.pslverr;
  assign mux_sel            = s.sel.mux;
  assign start_sel_a        = s.sel.start_a;
  assign start_sel_b        = s.sel.start_b;
  assign start_source_pulse = bkt_level;
  assign bucket_start       = s.bucket_start;
  assign sweep_active       = s.sweep_active;
  assign track_hold_strobe  = s.hold;
  assign dac_code           = sar_code;
  assign complete_n         = sar_complete_n;

endmodule : aisc_top

// [dv/aisc_monitor.sv]
`timescale 1ns/1ns
module aisc_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       pready,
  input wire logic [2:0] mux_sel,
  input wire logic       start_sel_a,
  input wire logic       start_sel_b,
  input wire logic       start_source_pulse,
  input wire logic       sweep_active,
  input wire logic       track_hold_strobe,
  input wire logic       complete_n
);
  // ------------------------------------------------------------
  // widths in pclk cycles, 100 per conversion tick
  // ------------------------------------------------------------
  logic [11:0] hold_n;
  logic [11:0] puls_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_n <= 12'h000;
      puls_n <= 12'h000;
    end else begin
      hold_n <= track_hold_strobe ? hold_n + 12'h001 : 12'h000;
      puls_n <= start_source_pulse ? puls_n + 12'h001 : 12'h000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_hold_mux_stable: assert property (
    track_hold_strobe && $past(track_hold_strobe) |-> $stable(mux_sel))
    else $error("mux select moved during hold");
  a_hold_sel_stable: assert property (
    track_hold_strobe && $past(track_hold_strobe)
    |-> $stable({start_sel_a, start_sel_b}))
    else $error("start select moved during hold");
  a_sel_not_both: assert property (
    !(start_sel_a && start_sel_b))
    else $error("both start selects high");
  a_pulse_in_sweep: assert property (
    $rose(start_source_pulse) |-> sweep_active)
    else $error("start pulse outside sweep");
  a_pulse_width: assert property (
    $fell(start_source_pulse) |-> puls_n inside {[1490:1510]})
    else $error("start pulse width wrong");
  a_hold_width: assert property (
    $fell(track_hold_strobe) |-> hold_n inside {[1790:1810]})
    else $error("hold strobe width wrong");
  a_done_in_hold: assert property (
    $fell(complete_n) |-> track_hold_strobe)
    else $error("completion outside hold");
  a_start_to_hold: assert property (
    $rose(start_source_pulse) && start_sel_a && !start_sel_b
    && !track_hold_strobe |-> ##[0:3] track_hold_strobe)
    else $error("start pulse gave no hold");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  c_done: cover property ($fell(complete_n));
  c_sweep: cover property ($rose(sweep_active));
  c_realign: cover property ($rose(start_sel_b));
endmodule : aisc_monitor

bind aisc_top aisc_monitor aisc_monitor_i (.pclk, .presetn, .pready,
  .mux_sel, .start_sel_a, .start_sel_b, .start_source_pulse,
  .sweep_active, .track_hold_strobe, .complete_n);

// [dv/aisc_board_model.sv]
`timescale 1ns/1ns
module aisc_board_model #(
  parameter logic [11:0] LEVEL = 12'h5a3
) (
  input  wire logic        pclk,
  input  wire logic [11:0] dac_code,
  output logic             conversion_clock,
  output logic             zero_span_bucket_pulse,
  output logic             ramp_bucket_end,
  output logic             comparator_high
);
  // ------------------------------------------------------------
  // 1 MHz clock from 100 MHz, runs free; bucket every 40 ticks
  // ------------------------------------------------------------
  logic [5:0] div = 6'h00;
  logic [5:0] bkt = 6'h00;
  initial conversion_clock = 1'b0;
  always @(posedge pclk) begin
    div <= (div == 6'h31) ? 6'h00 : div + 6'h01;
    if (div == 6'h31) begin
      conversion_clock <= ~conversion_clock;
      if (!conversion_clock) begin
        bkt <= (bkt == 6'h27) ? 6'h00 : bkt + 6'h01;
      end
    end
  end
  assign zero_span_bucket_pulse = (bkt == 6'h00);
  assign ramp_bucket_end        = (bkt == 6'h00);
  // held video level: trial above it is too high
  assign comparator_high        = (dac_code > LEVEL);
endmodule : aisc_board_model

// [dv/adc_input_select_start_control_tb_top.sv]
`timescale 1ns/1ns
module adc_input_select_start_control_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        conversion_clock, zero_span_bucket_pulse, ramp_bucket_end;
  logic        noise_detected, comparator_high, start_sel_a, start_sel_b;
  logic        start_source_pulse, bucket_start, sweep_active;
  logic        track_hold_strobe, complete_n, e, seen;
  logic [2:0]  mux_sel, m1;
  logic [11:0] dac_code;
  int          num_checks, n_mismatch, tk, t0;
  aisc_top aisc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .conversion_clock,
    .zero_span_bucket_pulse, .ramp_bucket_end, .noise_detected,
    .comparator_high, .mux_sel, .start_sel_a, .start_sel_b,
    .start_source_pulse, .bucket_start, .sweep_active, .track_hold_strobe,
    .dac_code, .complete_n);
  aisc_board_model aisc_board_model_i (.pclk, .dac_code, .conversion_clock,
    .zero_span_bucket_pulse, .ramp_bucket_end, .comparator_high);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge conversion_clock) tk++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wt(ref logic s, input logic v, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (s === v) break;
    end
  endtask : wt
  task automatic rst();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : rst
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #900000;
    n_mismatch++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  localparam logic [8:0] CTL[9] = '{9'h000, 9'h001, 9'h002, 9'h003,
    9'h008, 9'h010, 9'h030, 9'h050, 9'h070};
  localparam logic [2:0] MX[9] = '{3'h5, 3'h4, 3'h1, 3'h4, 3'h3, 3'h0,
    3'h2, 3'h6, 3'h7};
  initial begin
    {presetn, psel, penable, pwrite, noise_detected} = 5'h00;
    paddr  = 8'h00;
    pwdata = 32'h0;
    rst();
    chk(32'(mux_sel), 32'h5);
    chk(32'({start_sel_a, start_sel_b}), 32'h2);
    apb(1'b0, aisc_pkg::ADDR_BUCKET, 32'h0);
    chk(r, 32'h29b);
    apb(1'b0, aisc_pkg::ADDR_RETRACE, 32'h0);
    chk(r, 32'h3e8);
    apb(1'b1, aisc_pkg::ADDR_RESULT, 32'hffff);
    chk(32'(e), 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, e} + r, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, aisc_pkg::ADDR_CTRL, 32'(CTL[i]));
      repeat (4) @(posedge pclk);
      chk(32'(mux_sel), 32'(MX[i]));
      if (i == 3) chk(32'({start_sel_a, start_sel_b}), 32'h0);
    end
    apb(1'b1, aisc_pkg::ADDR_CTRL, 32'h80);
    repeat (4) @(posedge pclk);
    chk(32'({start_sel_a, start_sel_b}), 32'h1);
    $display("test selects done");
    rst();
    apb(1'b1, aisc_pkg::ADDR_BUCKET, 32'd20);
    apb(1'b1, aisc_pkg::ADDR_RETRACE, 32'd5);
    t0 = tk;
    apb(1'b1, aisc_pkg::ADDR_CTRL, 32'h100);
    wt(sweep_active, 1'b1, 2000);
    chk(32'(tk - t0 inside {[5:7]}), 32'h1);
    wt(start_source_pulse, 1'b1, 3000);
    t0 = tk;
    wt(complete_n, 1'b0, 3000);
    apb(1'b0, aisc_pkg::ADDR_RESULT, 32'h0);
    chk(32'(r[11:0]), 32'h5a3);
    chk(32'(dac_code), 32'h5a3);
    wt(start_source_pulse, 1'b0, 3000);
    wt(start_source_pulse, 1'b1, 3000);
    chk(32'(tk - t0), 32'd20);
    chk(32'(sweep_active), 32'h1);
    $display("test sweep done");
    rst();
    noise_detected <= 1'b1;
    apb(1'b1, aisc_pkg::ADDR_RETRACE, 32'd5);
    apb(1'b1, aisc_pkg::ADDR_CTRL, 32'h103);
    wt(track_hold_strobe, 1'b1, 20000);
    m1 = mux_sel;
    chk(32'(m1 == 3'h4 || m1 == 3'h1), 32'h1);
    wt(track_hold_strobe, 1'b0, 3000);
    wt(track_hold_strobe, 1'b1, 20000);
    chk(32'(mux_sel), (m1 == 3'h4) ? 32'h1 : 32'h4);
    t0 = tk;
    wt(bucket_start, 1'b0, 3000);
    wt(bucket_start, 1'b1, 20000);
    chk(32'(tk - t0), 32'd130);
    $display("test noise done");
    rst();
    noise_detected <= 1'b0;
    apb(1'b1, aisc_pkg::ADDR_CTRL, 32'h080);
    seen = 1'b0;
    repeat (5000) begin
      @(posedge pclk);
      seen = seen | track_hold_strobe;
    end
    chk(32'(seen), 32'h0);
    apb(1'b1, aisc_pkg::ADDR_CTRL, 32'h084);
    wt(track_hold_strobe, 1'b1, 6000);
    chk(32'(track_hold_strobe), 32'h1);
    $display("test zero span done");
    print_verdict();
  end
endmodule : adc_input_select_start_control_tb_top
